// ---- design/hbc_pkg.sv ----
// package for the host-side h-bridge controller
// assumes one 20 MHz clock and an external bridge driver on plain pins
package hbc_pkg;
  // clock period in ns
  localparam int CLK_PERIOD_NS = 50;
  // time the host gives itself to park every pin after a clear, in ns
  localparam int CLEAR_WINDOW_NS = 1000;
  localparam int CLEAR_WINDOW_CYC_RAW = CLEAR_WINDOW_NS / CLK_PERIOD_NS;
  // longest time rounds down, never below one cycle
  localparam int CLEAR_WINDOW_CYC = (CLEAR_WINDOW_CYC_RAW < 1) ? 1 : CLEAR_WINDOW_CYC_RAW;
  // width of the pulse on a direction input used to clear a fault, in cycles
  localparam int TOGGLE_LOW_CYC = 2;
  // cycles from raising a toggled direction input until its pin is judged:
  // one for the input flop, two for the sync chain, one to decide
  localparam int RELEASE_SETTLE_CYC = 4;
  localparam int CNT_W = 8;

  // commanded modes, encoded as {dir_a, dir_b}
  localparam logic [1:0] MODE_BRAKE_GND = 2'h0;
  localparam logic [1:0] MODE_CCW = 2'h1;
  localparam logic [1:0] MODE_CW = 2'h2;
  localparam logic [1:0] MODE_BRAKE_SUP = 2'h3;

  // user command toward the controller
  typedef struct packed {
    logic [1:0] mode;     // requested bridge mode
    logic pwm;            // pulse-width request
    logic park_a;         // hold leg a in high impedance
    logic park_b;         // hold leg b in high impedance
  } hbc_cmd_t;

  // diagnosis reported to the user
  typedef struct packed {
    logic fault_a;        // leg a reports a latched fault
    logic fault_b;        // leg b reports a latched fault
    logic standby;        // bridge parked after a persisting fault or after a clear while all parked
    logic busy;           // clear sequence in progress
  } hbc_stat_t;

  typedef enum logic [2:0] {
    HBC_RUN,
    HBC_TOG_LOW,
    HBC_TOG_HIGH,
    HBC_PARK,
    HBC_STBY
  } hbc_state_t;
endpackage : hbc_pkg

// ---- design/hbc_ctrl.sv ----
// host-side controller for an h-bridge driver with latching fault pins
// assumes the diag/enable pins have external pull-ups and the pins come
// from the driver asynchronously to mclk
// a clear parks the bridge only if the fault is still there after release or both legs were already parked with pwm low
//
// How it works
// R1 - pwm low turns both low sides off
// R2 - pwm high re-enables selected low side
// R3 - enables high: direction pair selects four modes
// R4 - host releases diag pins, pull-up holds high
// R5 - driver pulls faulty leg diag pin low
// R6 - faults: high-side overtemp, low-side saturation
// R7 - faulty leg latched off until cleared
// R8 - rising direction input edge clears latch
// R9 - host reads inputs and diag pins for fault
// R10 - persisting fault: toggle, then park all low
// R11 - all low already: toggle clears, enters standby
// R12 - held-low diag pin makes half-bridge high-z
// R13 - fault on one leg leaves other alone
`timescale 1ns/1ps
module hbc_ctrl
  import hbc_pkg::*;
(
  input wire logic mclk,             // 20 MHz clock
  input wire logic rst,              // async reset, active high
  input wire hbc_cmd_t cmd,          // user command
  input wire logic clear_req,        // one-cycle request to clear faults
  output hbc_stat_t stat,            // diagnosis
  output logic dir_in_a,             // direction input a
  output logic dir_in_b,             // direction input b
  output logic pwm_out,              // pulse-width input of the driver
  input wire logic diag_enable_a_i,  // pin level of diag/enable a
  output logic diag_enable_a_o,      // drive value, always low
  output logic diag_enable_a_oe,     // high while host pulls pin a low
  input wire logic diag_enable_b_i,  // pin level of diag/enable b
  output logic diag_enable_b_o,      // drive value, always low
  output logic diag_enable_b_oe      // high while host pulls pin b low
);
  hbc_state_t state_q, state_d;
  logic [1:0] sync_a_q, sync_b_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic dir_a_q, dir_b_q, pwm_q, oe_a_q, oe_b_q;
  logic dir_a_d, dir_b_d, pwm_d, oe_a_d, oe_b_d;
  logic tog_a_q, tog_a_d, tog_b_q, tog_b_d;
  logic [1:0] oe_a_h_q, oe_b_h_q;

  // a low pin only counts once our own pull has left the sync chain
  function automatic logic pin_fault(input logic pin_lvl, input logic oe_now,
                                     input logic [1:0] oe_hist);
    return !pin_lvl && !oe_now && !(|oe_hist);
  endfunction : pin_fault

  // a pin reads low while not driven by us only when the driver reports
  wire logic pin_a = sync_a_q[1];
  wire logic pin_b = sync_b_q[1];
  wire logic flt_a = pin_fault(pin_a, oe_a_q, oe_a_h_q); // [R5] [R6] [R9]
  wire logic flt_b = pin_fault(pin_b, oe_b_q, oe_b_h_q); // [R5] [R6] [R9]
  wire logic any_flt = flt_a || flt_b;
  // all parked already: a toggle alone finishes the clear
  wire logic all_low = !pwm_q && oe_a_q && oe_b_q; // [R11]

  // two-flop synchronisers on the pins coming back from the driver
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync_a_q <= 2'h3;
      sync_b_q <= 2'h3;
    end
    else
    begin
      sync_a_q <= {sync_a_q[0], diag_enable_a_i};
      sync_b_q <= {sync_b_q[0], diag_enable_b_i};
    end
  end

  // history of our own pulls, so that a pin we just released is not
  // mistaken for a fault while its low level is still in the sync chain
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      oe_a_h_q <= 2'h0;
      oe_b_h_q <= 2'h0;
    end
    else
    begin
      oe_a_h_q <= {oe_a_h_q[0], oe_a_q};
      oe_b_h_q <= {oe_b_h_q[0], oe_b_q};
    end
  end

  // sequencer for mode drive and fault clearing
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    tog_a_d = tog_a_q;
    tog_b_d = tog_b_q;
    // pwm gating happens in the driver; we just pass the request on
    pwm_d = cmd.pwm; // [R1] [R2]
    dir_a_d = cmd.mode[1]; // [R3]
    dir_b_d = cmd.mode[0]; // [R3]
    // release unless parking; pull-up then keeps the pin high
    oe_a_d = cmd.park_a; // [R4] [R12]
    oe_b_d = cmd.park_b; // [R4] [R12]
    case (state_q)
      HBC_RUN:
      begin
        if (clear_req && (any_flt || all_low))
        begin
          // remember which legs to toggle; a clean leg keeps running unless all are parked with its input high
          tog_a_d = flt_a || (all_low && dir_a_q);
          tog_b_d = flt_b || (all_low && dir_b_q);
          cnt_d = CNT_W'(TOGGLE_LOW_CYC);
          state_d = HBC_TOG_LOW;
        end
      end
      HBC_TOG_LOW:
      begin
        // only a toggled leg drops; the clean leg keeps following its request
        if (tog_a_q) dir_a_d = 1'b0; // [R13]
        if (tog_b_q) dir_b_d = 1'b0; // [R13]
        oe_a_d = oe_a_q;
        oe_b_d = oe_b_q;
        pwm_d = pwm_q;
        cnt_d = cnt_q - CNT_W'(1);
        if (cnt_q == CNT_W'(1))
        begin
          // time for the rising edge plus the sync chain before judging
          cnt_d = CNT_W'(RELEASE_SETTLE_CYC);
          state_d = HBC_TOG_HIGH;
        end
      end
      HBC_TOG_HIGH:
      begin
        // rising edge on a toggled direction input releases the latch
        if (tog_a_q) dir_a_d = 1'b1; // [R7] [R8]
        if (tog_b_q) dir_b_d = 1'b1; // [R7] [R8]
        oe_a_d = oe_a_q;
        oe_b_d = oe_b_q;
        pwm_d = pwm_q;
        cnt_d = cnt_q - CNT_W'(1);
        if (cnt_q == CNT_W'(1))
        begin
          // a pin still low after the release means the cause persists
          if (all_low)
          begin
            // standby forces the inputs low from its first cycle
            dir_a_d = 1'b0; // [R11]
            dir_b_d = 1'b0; // [R11]
            state_d = HBC_STBY; // [R11]
          end
          else if (any_flt) state_d = HBC_PARK; // [R10]
          else state_d = HBC_RUN; // [R8]
        end
      end
      HBC_PARK:
      begin
        // park everything low inside the window after the clear
        // one cycle here keeps well clear of the window's end
        dir_a_d = 1'b0; // [R10]
        dir_b_d = 1'b0; // [R10]
        pwm_d = 1'b0; // [R10]
        oe_a_d = 1'b1; // [R10]
        oe_b_d = 1'b1; // [R10]
        state_d = HBC_STBY;
      end
      HBC_STBY:
      begin
        dir_a_d = 1'b0;
        dir_b_d = 1'b0;
        pwm_d = 1'b0;
        oe_a_d = 1'b1;
        oe_b_d = 1'b1;
        // leave standby once the user releases both parks and drops pwm
        if (!cmd.park_a && !cmd.park_b && !cmd.pwm) state_d = HBC_RUN;
      end
      default: state_d = HBC_RUN;
    endcase
  end

  // state and pin registers; dir, pwm and enable outputs come straight from flops, stat is decoded from them
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= HBC_RUN;
      cnt_q <= '0;
      tog_a_q <= 1'b0;
      tog_b_q <= 1'b0;
      dir_a_q <= 1'b0;
      dir_b_q <= 1'b0;
      pwm_q <= 1'b0;
      oe_a_q <= 1'b0;
      oe_b_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      tog_a_q <= tog_a_d;
      tog_b_q <= tog_b_d;
      dir_a_q <= dir_a_d;
      dir_b_q <= dir_b_d;
      pwm_q <= pwm_d;
      oe_a_q <= oe_a_d;
      oe_b_q <= oe_b_d;
    end
  end

  assign dir_in_a = dir_a_q;
  assign dir_in_b = dir_b_q;
  assign pwm_out = pwm_q;
  assign diag_enable_a_o = 1'b0;
  assign diag_enable_b_o = 1'b0;
  assign diag_enable_a_oe = oe_a_q;
  assign diag_enable_b_oe = oe_b_q;
  assign stat.fault_a = flt_a;
  assign stat.fault_b = flt_b;
  assign stat.standby = (state_q == HBC_STBY);
  assign stat.busy = (state_q != HBC_RUN) && (state_q != HBC_STBY);
endmodule : hbc_ctrl

// ---- tb/hbc_asserts.sv ----
// checker on the controller pins
// bound into hbc_ctrl, sees its ports only
`timescale 1ns/1ps
module hbc_asserts
  import hbc_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic clear_req, // clear request
  input wire hbc_stat_t stat, // diagnosis
  input wire logic dir_in_a, // dir a
  input wire logic dir_in_b, // dir b
  input wire logic pwm_out, // pwm
  input wire logic diag_enable_a_i, // pin a
  input wire logic diag_enable_a_o, // drive a
  input wire logic diag_enable_a_oe, // enable a
  input wire logic diag_enable_b_o, // drive b
  input wire logic diag_enable_b_oe // enable b
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // open drain pins, so only ever pulled low
  property p_rel; !diag_enable_a_o && !diag_enable_b_o; endproperty
  a_rel: assert property (p_rel) else $error("diag pin driven high");
  // sync chain allows up to four edges
  property p_seen; (!diag_enable_a_i && !diag_enable_a_oe) [*4] |-> stat.fault_a; endproperty
  a_seen: assert property (p_seen) else $error("fault a not shown");
  sequence s_tog; !dir_in_a ##[1:6] dir_in_a; endsequence
  property p_tog;
    clear_req && stat.fault_a && !stat.busy && !stat.standby |=> stat.busy ##[1:3] s_tog;
  endproperty
  a_tog: assert property (p_tog) else $error("no rising edge on dir a");
  property p_park;
    stat.standby |-> !dir_in_a && !dir_in_b && !pwm_out && diag_enable_a_oe && diag_enable_b_oe;
  endproperty
  a_park: assert property (p_park) else $error("standby not parked");
  localparam int WIN = CLEAR_WINDOW_CYC;
  // our own pull must have left the sync chain before a fault is shown
  property p_src_a;
    stat.fault_a |-> !diag_enable_a_oe && !$past(diag_enable_a_oe)
      && !$past(diag_enable_a_oe, 2);
  endproperty
  a_src_a: assert property (p_src_a) else $error("fault a shown while parked");
  property p_src_b;
    stat.fault_b |-> !diag_enable_b_oe && !$past(diag_enable_b_oe)
      && !$past(diag_enable_b_oe, 2);
  endproperty
  a_src_b: assert property (p_src_b) else $error("fault b shown while parked");
  // after the releasing edge the clear ends, parked or running, inside the window
  property p_win;
    stat.busy && ($rose(dir_in_a) || $rose(dir_in_b)) |-> ##[1:WIN] !stat.busy;
  endproperty
  a_win: assert property (p_win) else $error("clear not finished in window");
endmodule : hbc_asserts
bind hbc_ctrl hbc_asserts u_chk (.mclk(mclk), .rst(rst), .clear_req(clear_req), .stat(stat),
  .dir_in_a(dir_in_a), .dir_in_b(dir_in_b), .pwm_out(pwm_out),
  .diag_enable_a_i(diag_enable_a_i), .diag_enable_a_o(diag_enable_a_o),
  .diag_enable_a_oe(diag_enable_a_oe), .diag_enable_b_o(diag_enable_b_o),
  .diag_enable_b_oe(diag_enable_b_oe));

// ---- tb/hbc_dev.sv ----
// behavioural bridge driver on the controller pins
// fault causes come from the bench, pin levels resolved outside
`timescale 1ns/1ps
module hbc_dev (
  input wire logic dir_a, // direction a
  input wire logic dir_b, // direction b
  input wire logic pwm, // pulse width
  input wire logic en_a, // pin level a
  input wire logic en_b, // pin level b
  input wire logic [1:0] ovt, // overtemperature per leg
  input wire logic [1:0] sat, // saturation per leg
  output logic pull_a, // pulls pin a low
  output logic pull_b, // pulls pin b low
  output logic [3:0] sw // hs_a ls_a hs_b ls_b
);
  logic lat_a = 1'b0;
  logic lat_b = 1'b0;
  wire cau_a = ovt[0] | sat[0];
  wire cau_b = ovt[1] | sat[1];
  // a persisting cause relatches at once
  always @(posedge cau_a or posedge dir_a) lat_a <= cau_a;
  always @(posedge cau_b or posedge dir_b) lat_b <= cau_b;
  assign pull_a = lat_a;
  assign pull_b = lat_b;
  // each leg decoded alone
  assign sw = {dir_a & en_a & ~lat_a, ~dir_a & pwm & en_a & ~lat_a,
               dir_b & en_b & ~lat_b, ~dir_b & pwm & en_b & ~lat_b};
endmodule : hbc_dev

// ---- tb/hbc_ctrl_tb.sv ----
// bench for hbc_ctrl with a bridge model on its pins
// pull-ups on both diag pins are modelled here
`timescale 1ns/1ps
module hbc_ctrl_tb import hbc_pkg::*;;
  logic mclk, rst, clear_req, dir_in_a, dir_in_b, pwm_out, a_o, a_oe, b_o, b_oe, pull_a, pull_b;
  hbc_cmd_t cmd;
  hbc_stat_t stat;
  logic [1:0] ovt, sat;
  logic [3:0] sw;
  int n_errors, checked;
  logic [6:0] rows [8] = '{7'h7a, 7'h6a, 7'h59, 7'h48, 7'h36, 7'h22, 7'h15, 7'h00};
  wire pin_a = !(a_oe | pull_a);
  wire pin_b = !(b_oe | pull_b);
  hbc_ctrl dut (.mclk(mclk), .rst(rst), .cmd(cmd), .clear_req(clear_req), .stat(stat),
    .dir_in_a(dir_in_a), .dir_in_b(dir_in_b), .pwm_out(pwm_out), .diag_enable_a_i(pin_a),
    .diag_enable_a_o(a_o), .diag_enable_a_oe(a_oe), .diag_enable_b_i(pin_b),
    .diag_enable_b_o(b_o), .diag_enable_b_oe(b_oe));
  hbc_dev u_dev (.dir_a(dir_in_a), .dir_b(dir_in_b), .pwm(pwm_out), .en_a(pin_a), .en_b(pin_b),
    .ovt(ovt), .sat(sat), .pull_a(pull_a), .pull_b(pull_b), .sw(sw));
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic go(input logic [4:0] c, input int n);
    @(negedge mclk);
    cmd = c;
    // a clear request is a single-cycle pulse
    clear_req = (n == 30);
    @(negedge mclk);
    clear_req = 1'b0;
    repeat (n - 1) @(negedge mclk);
  endtask : go
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // about 210 cycles expected, so 1000 is ample
  initial
  begin
    #50000;
    n_errors++;
    finish_test();
  end
  initial
  begin
    {rst, cmd, clear_req, ovt, sat} = {1'b1, 10'h0};
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    cmp({dir_in_a, dir_in_b, pwm_out, a_oe}, 4'h0);
    foreach (rows[i])
    begin
      go({rows[i][6:4], 2'h0}, 3);
      cmp(sw, rows[i][3:0]);
    end
    go(5'h16, 3);
    cmp(sw, 4'h1);
    go(5'h14, 3);
    ovt = 2'h1;
    go(5'h14, 5);
    cmp({stat.fault_a, sw[3], sw[0], pin_a}, 4'ha);
    ovt = 2'h0;
    go(5'h14, 30);
    cmp({stat.fault_a, sw[3], stat.standby, stat.busy}, 4'h4);
    sat = 2'h2;
    go(5'h14, 5);
    go(5'h14, 30);
    cmp({stat.standby, dir_in_b, pwm_out, b_oe}, 4'h9);
    cmp(sw, 4'h0);
    // reset in mid-run drops every host pull and every drive at once
    rst = 1'b1;
    sat = 2'h0;
    @(negedge mclk);
    cmp({a_oe, b_oe, dir_in_a, pwm_out}, 4'h0);
    rst = 1'b0;
    go(5'h14, 5);
    cmp({stat.fault_b, stat.fault_a, pin_b, b_oe}, 4'h8);
    go(5'h14, 30);
    cmp({stat.fault_b, sw[0], stat.standby, stat.busy}, 4'h4);
    // everything parked already: a toggle alone ends in standby
    go(5'h13, 5);
    go(5'h13, 30);
    cmp({stat.standby, stat.busy, dir_in_a, a_oe}, 4'h9);
    finish_test();
  end
endmodule : hbc_ctrl_tb
